// ==== design/secopt_handler.sv ====
/*
 * Security-option command handler: parses host command frames from a
 * byte stream, answers with status or information frames, and holds the
 * live security settings, which software also reaches over APB.
 * Assumes bytes arrive already deserialised, synchronous to CLK_I, and
 * that code/data flash blank state and option-area facts come as levels.
 */
// Operation
// - Security-set writes take effect immediately
// - Release refused if erase or boot protect zero
// - Locked write-protect never returns to one
// - Info frame header 02h, length 08h
// - Flag bit 0 reports boot cluster select
// - Bits 1,2 report boot-protect, erase-protect
// - Bits 4,7 report write, test-mode permission
// - Flag bits 3, 5, 6 read one
// - Boot-area last block follows flag byte
// - Window start, ten bits, low byte first
// - Window end minus one, low first
// - ACK frame: 02 01 06 F9 03
// - Error frame: 02 01 status sum 03
// - ACK first, then read and send info
// - Security-get leaves flash unchanged
// - Missing terminator or bad length gives NACK
// - Checksum mismatch gives checksum error
// - Disallowed command gives command number error
// - Release erases options only when all blank
// - Non-blank flash gives blank error, untouched
`timescale 1ns/1ps

module secopt_handler #(
    parameter logic [7:0] STS_NACK = 8'h15,
    parameter logic [7:0] STS_CHECKSUM_ERR = 8'h07,
    parameter logic [7:0] STS_CMD_ERR = 8'h04,
    parameter logic [7:0] STS_PROTECT_ERR = 8'h10,
    parameter logic [7:0] STS_BLANK_ERR = 8'h1B
) (
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire logic CE_I,
    // APB slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // Byte link
    input wire logic RX_VALID_I,
    input wire logic [7:0] RX_DATA_I,
    output logic RX_READY_O,
    output logic TX_VALID_O,
    output logic [7:0] TX_DATA_O,
    input wire logic TX_READY_I,
    // Flash facts
    input wire logic CODE_BLANK_I,
    input wire logic DATA_BLANK_I,
    input wire logic OPT_C4_BIT0_I,
    input wire logic DF_TAIL_ERASED_I,
    // Live settings
    output logic [7:0] SEC_FLAGS_O,
    output logic [7:0] BOOT_BLOCK_O,
    output logic [9:0] WIN_START_O,
    output logic [9:0] WIN_END_O
);

    typedef enum logic [6:0] {
        ST_HUNT = 7'b000_0001,
        ST_LEN = 7'b000_0010,
        ST_BODY = 7'b000_0100,
        ST_SUM = 7'b000_1000,
        ST_ETX = 7'b001_0000,
        ST_EVAL = 7'b010_0000,
        ST_TX = 7'b100_0000
    } state_t;

    state_t state_r;
    logic [7:0] len_r;
    logic [7:0] cnt_r;
    logic [7:0] cmd_r;
    logic [7:0] sum_acc_r;
    logic [7:0] rx_sum_r;
    logic etx_ok_r;
    logic info_pend_r;
    logic [7:0] pay_r [0:7];
    logic [7:0] tx_len_r;
    logic [3:0] tx_idx_r;
    logic [7:0] tx_sum_r;
    logic [7:0] tx_byte;
    logic [3:0] tx_last;
    logic [7:0] last_sts_r;
    logic cmd_en_r;
    logic wr_lock_r;
    logic [7:0] flags_r;
    logic [7:0] boot_blk_r;
    logic [9:0] win_start_r;
    logic [9:0] win_end_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic rx_take;
    logic apb_setup;
    logic apb_wr;
    logic release_ok;
    logic [7:0] flag_byte;
    logic [7:0] flags_wr;
    logic [9:0] win_end_m1;

    assign rx_take = CE_I && RX_VALID_I && (state_r != ST_EVAL) && (state_r != ST_TX);
    assign apb_setup = PSEL_I && !PENABLE_I;
    assign apb_wr = PSEL_I && PENABLE_I && pready_r && PWRITE_I;

    ////////////////////////////////////////////////////////////////////
    // Reported flag byte

    always_comb begin
        flag_byte = flags_r | secopt_pkg::FLG_FIXED_ONES;
        flag_byte[secopt_pkg::FLG_BOOT_SELECT] =
            flags_r[secopt_pkg::FLG_BOOT_SELECT];
        flag_byte[secopt_pkg::FLG_BOOT_PROTECT] =
            flags_r[secopt_pkg::FLG_BOOT_PROTECT];
        flag_byte[secopt_pkg::FLG_ERASE_PROTECT] =
            flags_r[secopt_pkg::FLG_ERASE_PROTECT];
        flag_byte[secopt_pkg::FLG_WRITE_PROTECT] =
            flags_r[secopt_pkg::FLG_WRITE_PROTECT];
        flag_byte[secopt_pkg::FLG_TEST_PROTECT] =
            flags_r[secopt_pkg::FLG_TEST_PROTECT];
    end

    assign win_end_m1 = win_end_r - 10'h001;

    // Boot, erase and write protection bits may only be lowered by software, never raised
    always_comb begin
        flags_wr = PWDATA_I[7:0];
        flags_wr[secopt_pkg::FLG_BOOT_PROTECT] = PWDATA_I[secopt_pkg::FLG_BOOT_PROTECT]
            & flags_r[secopt_pkg::FLG_BOOT_PROTECT];
        flags_wr[secopt_pkg::FLG_ERASE_PROTECT] = PWDATA_I[secopt_pkg::FLG_ERASE_PROTECT]
            & flags_r[secopt_pkg::FLG_ERASE_PROTECT];
        flags_wr[secopt_pkg::FLG_WRITE_PROTECT] = PWDATA_I[secopt_pkg::FLG_WRITE_PROTECT]
            & flags_r[secopt_pkg::FLG_WRITE_PROTECT];
    end

    // Release needs both protections still at one and all flash blank
    assign release_ok = flags_r[secopt_pkg::FLG_ERASE_PROTECT]
        && flags_r[secopt_pkg::FLG_BOOT_PROTECT]
        && CODE_BLANK_I && DATA_BLANK_I;

    ////////////////////////////////////////////////////////////////////
    // Security settings

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            flags_r <= secopt_pkg::FLAGS_ERASED;
            boot_blk_r <= secopt_pkg::BOOT_BLOCK_ERASED;
            win_start_r <= secopt_pkg::WIN_START_ERASED;
            win_end_r <= secopt_pkg::WIN_END_ERASED;
        end else if (CE_I) begin
            if (state_r == ST_EVAL && etx_ok_r && len_r == secopt_pkg::LEN_COMMAND
                && cmd_en_r && cmd_r == secopt_pkg::CMD_SEC_RELEASE && release_ok
                && (sum_acc_r + rx_sum_r) == 8'h00) begin
                // Erased state, live at once; a locked write bit stays low
                flags_r <= secopt_pkg::FLAGS_ERASED;
                flags_r[secopt_pkg::FLG_WRITE_PROTECT] <= !wr_lock_r;
                boot_blk_r <= secopt_pkg::BOOT_BLOCK_ERASED;
                win_start_r <= secopt_pkg::WIN_START_ERASED;
                win_end_r <= secopt_pkg::WIN_END_ERASED;
            end else if (apb_wr) begin
                unique case (PADDR_I)
                    secopt_pkg::REG_FLAGS: flags_r <= flags_wr;
                    secopt_pkg::REG_WINDOW: begin
                        win_start_r <= PWDATA_I[secopt_pkg::WIN_START_LSB +: 10];
                        win_end_r <= PWDATA_I[secopt_pkg::WIN_END_LSB +: 10];
                    end
                    secopt_pkg::REG_BOOT_BLOCK: boot_blk_r <= PWDATA_I[7:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // Write-protect lock, caught when the bit is cleared under the condition
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            wr_lock_r <= 1'b0;
        end else if (CE_I) begin
            if (apb_wr && PADDR_I == secopt_pkg::REG_FLAGS
                && flags_r[secopt_pkg::FLG_WRITE_PROTECT]
                && !PWDATA_I[secopt_pkg::FLG_WRITE_PROTECT]
                && OPT_C4_BIT0_I && DF_TAIL_ERASED_I) begin
                wr_lock_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB slave, no wait state; read data comes from a flop loaded in the setup cycle

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else if (CE_I) begin
            pready_r <= apb_setup;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            if (apb_setup) begin
                unique case (PADDR_I)
                    secopt_pkg::REG_FLAGS: prdata_r <= {24'h00_0000, flag_byte};
                    secopt_pkg::REG_WINDOW: begin
                        prdata_r <= {6'h00, win_end_r, 6'h00, win_start_r};
                    end
                    secopt_pkg::REG_BOOT_BLOCK: prdata_r <= {24'h00_0000, boot_blk_r};
                    secopt_pkg::REG_CTRL: prdata_r <= {31'h0000_0000, cmd_en_r};
                    secopt_pkg::REG_STATUS: begin
                        prdata_r <= {22'h00_0000, wr_lock_r, (state_r != ST_HUNT),
                            last_sts_r};
                    end
                    default: pslverr_r <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            cmd_en_r <= 1'b1;
        end else if (CE_I && apb_wr && PADDR_I == secopt_pkg::REG_CTRL) begin
            cmd_en_r <= PWDATA_I[secopt_pkg::CTRL_CMD_ENABLE];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outgoing byte selection

    assign tx_last = 4'(tx_len_r) + 4'd3;

    always_comb begin
        tx_byte = secopt_pkg::FRAME_END;
        if (tx_idx_r == 4'd0) begin
            tx_byte = secopt_pkg::DATA_HEADER;
        end else if (tx_idx_r == 4'd1) begin
            tx_byte = tx_len_r;
        end else if (tx_idx_r < tx_last - 4'd1) begin
            tx_byte = pay_r[3'(tx_idx_r - 4'd2)];
        end else if (tx_idx_r == tx_last - 4'd1) begin
            tx_byte = 8'h00 - tx_sum_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Frame receive, evaluate and answer

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            state_r <= ST_HUNT;
            len_r <= 8'h00;
            cnt_r <= 8'h00;
            cmd_r <= 8'h00;
            sum_acc_r <= 8'h00;
            rx_sum_r <= 8'h00;
            etx_ok_r <= 1'b0;
            info_pend_r <= 1'b0;
            tx_len_r <= secopt_pkg::LEN_STATUS;
            tx_idx_r <= 4'd0;
            tx_sum_r <= 8'h00;
            TX_VALID_O <= 1'b0;
            TX_DATA_O <= 8'h00;
            last_sts_r <= secopt_pkg::STATUS_RST;
            for (int i = 0; i < 8; i++) begin
                pay_r[i] <= 8'h00;
            end
        end else if (CE_I) begin
            unique case (state_r)
                ST_HUNT: begin
                    // Anything before a command header is dropped
                    if (rx_take && RX_DATA_I == secopt_pkg::CMD_HEADER) begin
                        state_r <= ST_LEN;
                    end
                end
                ST_LEN: begin
                    if (rx_take) begin
                        len_r <= RX_DATA_I;
                        sum_acc_r <= RX_DATA_I;
                        cnt_r <= 8'h00;
                        state_r <= (RX_DATA_I == 8'h00) ? ST_SUM : ST_BODY;
                    end
                end
                ST_BODY: begin
                    if (rx_take) begin
                        if (cnt_r == 8'h00) begin
                            cmd_r <= RX_DATA_I;
                        end
                        sum_acc_r <= sum_acc_r + RX_DATA_I;
                        cnt_r <= cnt_r + 8'h01;
                        if (cnt_r == len_r - 8'h01) begin
                            state_r <= ST_SUM;
                        end
                    end
                end
                ST_SUM: begin
                    if (rx_take) begin
                        rx_sum_r <= RX_DATA_I;
                        state_r <= ST_ETX;
                    end
                end
                ST_ETX: begin
                    if (rx_take) begin
                        etx_ok_r <= (RX_DATA_I == secopt_pkg::FRAME_END);
                        state_r <= ST_EVAL;
                    end
                end
                ST_EVAL: begin
                    tx_len_r <= secopt_pkg::LEN_STATUS;
                    tx_idx_r <= 4'd0;
                    tx_sum_r <= 8'h00;
                    info_pend_r <= 1'b0;
                    state_r <= ST_TX;
                    // Check order: terminator, checksum, command, length
                    if (!etx_ok_r) begin
                        pay_r[0] <= STS_NACK;
                    end else if ((sum_acc_r + rx_sum_r) != 8'h00) begin
                        pay_r[0] <= STS_CHECKSUM_ERR;
                    end else if (!cmd_en_r || (cmd_r != secopt_pkg::CMD_SEC_GET
                        && cmd_r != secopt_pkg::CMD_SEC_RELEASE)) begin
                        pay_r[0] <= STS_CMD_ERR;
                    end else if (len_r != secopt_pkg::LEN_COMMAND) begin
                        pay_r[0] <= STS_NACK;
                    end else if (cmd_r == secopt_pkg::CMD_SEC_GET) begin
                        // Read only; no flash or option change here
                        pay_r[0] <= secopt_pkg::STATUS_ACK;
                        info_pend_r <= 1'b1;
                    end else if (!flags_r[secopt_pkg::FLG_ERASE_PROTECT]
                        || !flags_r[secopt_pkg::FLG_BOOT_PROTECT]) begin
                        pay_r[0] <= STS_PROTECT_ERR;
                    end else if (!CODE_BLANK_I || !DATA_BLANK_I) begin
                        pay_r[0] <= STS_BLANK_ERR;
                    end else begin
                        pay_r[0] <= secopt_pkg::STATUS_ACK;
                    end
                end
                ST_TX: begin
                    if (!TX_VALID_O || TX_READY_I) begin
                        if (tx_idx_r <= tx_last) begin
                            TX_DATA_O <= tx_byte;
                            TX_VALID_O <= 1'b1;
                            tx_idx_r <= tx_idx_r + 4'd1;
                            if (tx_idx_r != 4'd0) begin
                                tx_sum_r <= tx_sum_r + tx_byte;
                            end
                            if (tx_idx_r == 4'd2) begin
                                last_sts_r <= (tx_len_r == secopt_pkg::LEN_STATUS)
                                    ? pay_r[0] : last_sts_r;
                            end
                        end else begin
                            TX_VALID_O <= 1'b0;
                            tx_idx_r <= 4'd0;
                            tx_sum_r <= 8'h00;
                            if (info_pend_r) begin
                                // Flags sampled only after the ACK has gone out
                                info_pend_r <= 1'b0;
                                tx_len_r <= secopt_pkg::LEN_INFO;
                                pay_r[0] <= flag_byte;
                                pay_r[1] <= boot_blk_r;
                                pay_r[2] <= win_start_r[7:0];
                                pay_r[3] <= {6'h00, win_start_r[9:8]};
                                pay_r[4] <= win_end_m1[7:0];
                                pay_r[5] <= {6'h00, win_end_m1[9:8]};
                                pay_r[6] <= secopt_pkg::RESERVED_FILL;
                                pay_r[7] <= secopt_pkg::RESERVED_FILL;
                            end else begin
                                state_r <= ST_HUNT;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // Link inputs ignored while answering; host holds off meanwhile
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            RX_READY_O <= 1'b0;
        end else if (CE_I) begin
            RX_READY_O <= 1'b1;
            if (state_r == ST_ETX && rx_take) begin
                RX_READY_O <= 1'b0;
            end else if (state_r == ST_EVAL || state_r == ST_TX) begin
                RX_READY_O <= (state_r == ST_TX) && (tx_idx_r > tx_last) && !info_pend_r
                    && (!TX_VALID_O || TX_READY_I);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            SEC_FLAGS_O <= secopt_pkg::FLAGS_ERASED;
            BOOT_BLOCK_O <= secopt_pkg::BOOT_BLOCK_ERASED;
            WIN_START_O <= secopt_pkg::WIN_START_ERASED;
            WIN_END_O <= secopt_pkg::WIN_END_ERASED;
        end else if (CE_I) begin
            SEC_FLAGS_O <= flags_r;
            BOOT_BLOCK_O <= boot_blk_r;
            WIN_START_O <= win_start_r;
            WIN_END_O <= win_end_r;
        end
    end

    assign PRDATA_O = prdata_r;
    assign PREADY_O = pready_r;
    assign PSLVERR_O = pslverr_r;

endmodule

// ==== design/secopt_pkg.sv ====
/*
 * Constants for the security-option command handler: frame bytes,
 * command codes, flag bit positions, register map and reset values.
 * Assumes a byte-wide link carrying framed packets in both directions.
 */
package secopt_pkg;

    // Frame bytes
    localparam logic [7:0] CMD_HEADER = 8'h01;
    localparam logic [7:0] DATA_HEADER = 8'h02;
    localparam logic [7:0] FRAME_END = 8'h03;
    localparam logic [7:0] CMD_SEC_GET = 8'hA1;
    localparam logic [7:0] CMD_SEC_RELEASE = 8'hA2;
    localparam logic [7:0] LEN_COMMAND = 8'h01;
    localparam logic [7:0] LEN_STATUS = 8'h01;
    localparam logic [7:0] LEN_INFO = 8'h08;
    localparam logic [7:0] STATUS_ACK = 8'h06;
    localparam logic [7:0] RESERVED_FILL = 8'hFF;

    // Flag byte bit positions
    localparam int FLG_BOOT_SELECT = 0;
    localparam int FLG_BOOT_PROTECT = 1;
    localparam int FLG_ERASE_PROTECT = 2;
    localparam int FLG_WRITE_PROTECT = 4;
    localparam int FLG_TEST_PROTECT = 7;
    // Bits that always read as one
    localparam logic [7:0] FLG_FIXED_ONES = 8'h68;

    // Register byte offsets
    localparam logic [7:0] REG_FLAGS = 8'h00;
    localparam logic [7:0] REG_WINDOW = 8'h04;
    localparam logic [7:0] REG_BOOT_BLOCK = 8'h08;
    localparam logic [7:0] REG_CTRL = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;

    // Window and control register fields
    localparam int WIN_START_LSB = 0;
    localparam int WIN_END_LSB = 16;
    localparam int CTRL_CMD_ENABLE = 0;

    // Values after reset and after release (erased option state; release keeps a locked write bit low); STATUS_RST after reset only
    localparam logic [7:0] FLAGS_ERASED = 8'hFF;
    localparam logic [7:0] BOOT_BLOCK_ERASED = 8'h00;
    localparam logic [9:0] WIN_START_ERASED = 10'h000;
    localparam logic [9:0] WIN_END_ERASED = 10'h000;
    localparam logic [7:0] STATUS_RST = 8'h00;

endpackage

// ==== sim/secopt_handler_sva.sv ====
/* Port checker for the security-option handler.
   Assumes one clock, CLK_I, and a synchronous active-high SRST_I. */
`timescale 1ns/1ps
module secopt_handler_sva (
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire logic CE_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic TX_VALID_O,
    input wire logic [7:0] TX_DATA_O,
    input wire logic TX_READY_I,
    input wire logic CODE_BLANK_I,
    input wire logic DATA_BLANK_I,
    input wire logic OPT_C4_BIT0_I,
    input wire logic DF_TAIL_ERASED_I,
    input wire logic [7:0] SEC_FLAGS_O,
    input wire logic [9:0] WIN_START_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (SRST_I);
    wire setup = PSEL_I && !PENABLE_I && CE_I;
    logic locked_r;
    // Lock is only seen once the flag output falls
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            locked_r <= 1'b0;
        end else if ($fell(SEC_FLAGS_O[4]) && OPT_C4_BIT0_I && DF_TAIL_ERASED_I) begin
            locked_r <= 1'b1;
        end
    end
    apb_ready_a: assert property (setup |=> PREADY_O)
        else $error("no ready in first access cycle");
    ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready held too long");
    unmapped_err_a: assert property (setup && !PWRITE_I && PADDR_I > 8'h10
        |=> PSLVERR_O && PRDATA_O == 32'h0000_0000)
        else $error("unmapped read not refused");
    tx_hold_a: assert property (TX_VALID_O && !TX_READY_I && CE_I
        |=> TX_VALID_O && $stable(TX_DATA_O))
        else $error("tx byte dropped before ready");
    window_live_a: assert property (
        setup && PWRITE_I && PADDR_I == 8'h04 ##1 PREADY_O
        |=> ##1 {22'h00_0000, WIN_START_O} == ($past(PWDATA_I, 2) & 32'h0000_03FF))
        else $error("window start not live");
    prot_rise_a: assert property (!$rose(SEC_FLAGS_O[1]) && !$rose(SEC_FLAGS_O[2]))
        else $error("protect flag raised");
    wp_lock_a: assert property (locked_r |-> !$rose(SEC_FLAGS_O[4]))
        else $error("locked write flag raised");
    blank_keep_a: assert property (
        ((!CODE_BLANK_I || !DATA_BLANK_I) && !PSEL_I)[*3]
        |-> $stable(SEC_FLAGS_O) && $stable(WIN_START_O))
        else $error("settings changed while not blank");
endmodule
bind secopt_handler secopt_handler_sva chk (.CLK_I(CLK_I), .SRST_I(SRST_I), .CE_I(CE_I),
    .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
    .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .TX_VALID_O(TX_VALID_O), .TX_DATA_O(TX_DATA_O), .TX_READY_I(TX_READY_I),
    .CODE_BLANK_I(CODE_BLANK_I), .DATA_BLANK_I(DATA_BLANK_I), .OPT_C4_BIT0_I(OPT_C4_BIT0_I),
    .DF_TAIL_ERASED_I(DF_TAIL_ERASED_I), .SEC_FLAGS_O(SEC_FLAGS_O), .WIN_START_O(WIN_START_O));

// ==== sim/secopt_host.sv ====
/* Host programmer model on the byte link: sends command frames and
   collects answer bytes. Assumes one-cycle byte strobes into the handler. */
`timescale 1ns/1ps
module secopt_host (
    input wire logic clk_i,
    input wire logic slow_i,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o
);
    logic [7:0] got_q[$];
    initial begin
        rx_valid_o = 1'b0;
        rx_data_o = 8'h00;
        tx_ready_o = 1'b1;
    end
    // Slow mode stalls every other cycle
    always @(posedge clk_i) begin
        if (tx_valid_i && tx_ready_o) begin
            got_q.push_back(tx_data_i);
        end
        tx_ready_o <= slow_i ? !tx_ready_o : 1'b1;
    end
    task automatic send_byte(input logic [7:0] b);
        @(posedge clk_i);
        rx_valid_o <= 1'b1;
        rx_data_o <= b;
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        // Idle line shows the inverse, never a stale copy
        rx_data_o <= ~b;
    endtask
    // Caller sends only after the whole answer
    task automatic send_frame(input logic [7:0] len, input logic [7:0] cmd,
        input logic [7:0] sum, input logic [7:0] etx);
        send_byte(8'h01);
        send_byte(len);
        send_byte(cmd);
        send_byte(sum);
        send_byte(etx);
    endtask
endmodule

// ==== sim/test_secopt_handler.sv ====
/* Self-checking bench for the security-option handler: APB master tasks
   and a host model on the byte link. Assumes a 40 MHz clock. */
`timescale 1ns/1ps
module test_secopt_handler;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rx_valid;
    logic [7:0] rx_data;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_ready;
    logic code_blank = 1'b1;
    logic slow = 1'b0;
    logic [31:0] rd;
    logic [7:0] blk;
    logic [9:0] wend;
    logic rdy;
    logic err;
    logic [31:0] bad[2] = '{32'h015E_0415, 32'h015F_0307};
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    always #12.5 clk = ~clk;
    secopt_handler dut (.CLK_I(clk), .SRST_I(srst), .CE_I(1'b1), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .RX_VALID_I(rx_valid),
        .RX_DATA_I(rx_data), .RX_READY_O(rdy), .TX_VALID_O(tx_valid), .TX_DATA_O(tx_data),
        .TX_READY_I(tx_ready), .CODE_BLANK_I(code_blank), .DATA_BLANK_I(1'b1),
        .OPT_C4_BIT0_I(1'b1), .DF_TAIL_ERASED_I(1'b1), .SEC_FLAGS_O(), .BOOT_BLOCK_O(blk),
        .WIN_START_O(), .WIN_END_O(wend));
    secopt_host host (.clk_i(clk), .slow_i(slow), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
        .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data));
    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (num_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            stop_test();
        end
    end
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic exp_byte(input logic [7:0] b);
        while (host.got_q.size() == 0) @(posedge clk);
        chk8(host.got_q.pop_front(), b);
    endtask
    // Answer frame with the negated running sum from length on
    task automatic exp_frame(input logic [7:0] p[$]);
        logic [7:0] s;
        s = 8'(p.size());
        exp_byte(8'h02);
        exp_byte(s);
        foreach (p[i]) begin
            exp_byte(p[i]);
            s = s + p[i];
        end
        exp_byte(-s);
        exp_byte(8'h03);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        apb(1'b0, secopt_pkg::REG_CTRL, 32'h0000_0000);
        chk32(rd, 32'h0000_0001);
        chk8({7'h00, rdy}, 8'h01);
        apb(1'b0, 8'h14, 32'h0000_0000);
        chk8({7'h00, err}, 8'h01);
        chk32(rd, 32'h0000_0000);
        host.send_frame(8'h01, 8'hA1, 8'h5E, 8'h03);
        exp_frame('{8'h06});
        exp_frame('{8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h03, 8'hFF, 8'hFF});
        apb(1'b1, secopt_pkg::REG_WINDOW, 32'h0141_0002);
        apb(1'b1, secopt_pkg::REG_BOOT_BLOCK, 32'h0000_0007);
        apb(1'b1, secopt_pkg::REG_FLAGS, 32'h0000_00EE);
        apb(1'b0, secopt_pkg::REG_FLAGS, 32'h0000_0000);
        chk32(rd, 32'h0000_00EE);
        chk8(blk, 8'h07);
        chk32({22'h00_0000, wend}, 32'h0000_0141);
        slow <= 1'b1;
        host.send_frame(8'h01, 8'hA1, 8'h5E, 8'h03);
        exp_frame('{8'h06});
        exp_frame('{8'hEE, 8'h07, 8'h02, 8'h00, 8'h40, 8'h01, 8'hFF, 8'hFF});
        foreach (bad[i]) begin
            host.send_frame(bad[i][31:24], 8'hA1, bad[i][23:16], bad[i][15:8]);
            exp_frame('{bad[i][7:0]});
        end
        host.send_frame(8'h02, 8'hA1, 8'h00, 8'h5D);
        host.send_byte(8'h03);
        exp_frame('{8'h15});
        apb(1'b1, secopt_pkg::REG_CTRL, 32'h0000_0000);
        host.send_frame(8'h01, 8'hA1, 8'h5E, 8'h03);
        exp_frame('{8'h04});
        apb(1'b1, secopt_pkg::REG_CTRL, 32'h0000_0001);
        code_blank <= 1'b0;
        host.send_frame(8'h01, 8'hA2, 8'h5D, 8'h03);
        exp_frame('{8'h1B});
        apb(1'b0, secopt_pkg::REG_WINDOW, 32'h0000_0000);
        chk32(rd, 32'h0141_0002);
        code_blank <= 1'b1;
        host.send_frame(8'h01, 8'hA2, 8'h5D, 8'h03);
        exp_frame('{8'h06});
        host.send_frame(8'h01, 8'hA1, 8'h5E, 8'h03);
        exp_frame('{8'h06});
        exp_frame('{8'hEF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h03, 8'hFF, 8'hFF});
        apb(1'b1, secopt_pkg::REG_FLAGS, 32'h0000_0093);
        host.send_frame(8'h01, 8'hA2, 8'h5D, 8'h03);
        exp_frame('{8'h10});
        apb(1'b0, secopt_pkg::REG_FLAGS, 32'h0000_0000);
        chk32(rd, 32'h0000_00EB);
        stop_test();
    end
endmodule
